// file: dv/irq_enable_and_key_flag_regs_bench.sv
// Purpose: random and corner tests of the enable and key flag registers
// Assumes: apb answers by pready, no fixed wait assumed
// Notes:   key pins are raised once; flags set on edges and by register writes
module irq_enable_and_key_flag_regs_bench
   import irq_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // bench
   // ****
   logic              clk, rst_n, psel, penable, pwrite, pready, err, irq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, seed;
   logic [3:0]        pstrb, key, key_irq_req;
   logic [7:0]        ev;
   logic [5:0]        serial_irq_req;
   logic [1:0]        timer_conv_irq_req;
   logic              pslverr;
   int                n_mismatch, comparisons, cyc;
   irq_enable_and_key_flag_regs irq_enable_and_key_flag_regs_i (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ser1_tx_empty_ev(ev[5]), .ser1_rx_full_ev(ev[4]),
      .ser1_rx_error_ev(ev[3]), .ser0_tx_empty_ev(ev[2]),
      .ser0_rx_full_ev(ev[1]), .ser0_rx_error_ev(ev[0]),
      .clock_timer_ev(ev[7]), .converter_done_ev(ev[6]),
      .port5_group_in(key[3]), .port6_group_in(key[2]),
      .key_line4_in(key[1]), .key_line5_in(key[0]),
      .serial_irq_req(serial_irq_req),
      .timer_conv_irq_req(timer_conv_irq_req),
      .key_irq_req(key_irq_req), .irq(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction : lfsr
   function automatic logic [31:0] tc_read(input logic [31:0] w);
      return {24'h0, 6'h3F, w[1:0]};
   endfunction : tc_read
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : check
   // the #1 lets the closing edge land before callers look at outputs
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 8'h00;
   endtask : pulse
   task automatic final_report;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report;
      end
   end
   initial begin
      {rst_n, psel, penable, pwrite, ev, key, paddr, pwdata} = '0;
      pstrb = 4'h1;
      seed = 32'h51E06D52;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, SERIAL_EN_ADDR, 0);
      check(rd, 32'h0);
      apb(0, TIMCONV_EN_ADDR, 0);
      check(rd, tc_read(0));
      apb(0, IRQ_MASK_ADDR + 22'h4, 0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         apb(1, SERIAL_EN_ADDR, seed);
         apb(0, SERIAL_EN_ADDR, 0);
         check(rd, {26'h0, seed[5:0]});
         apb(1, TIMCONV_EN_ADDR, seed | 32'hFC);
         apb(0, TIMCONV_EN_ADDR, 0);
         check(rd, tc_read(seed));
      end
      apb(1, SERIAL_EN_ADDR, 0);
      apb(1, TIMCONV_EN_ADDR, 32'hFC);
      apb(1, IRQ_STAT_ADDR, 32'hFFF);
      pulse(8'hFF);
      apb(0, IRQ_STAT_ADDR, 0);
      check(rd, 32'hC3F);
      check({serial_irq_req, timer_conv_irq_req, irq}, 0);
      apb(1, SERIAL_EN_ADDR, 32'h3F);
      apb(1, TIMCONV_EN_ADDR, 32'hFF);
      check({serial_irq_req, timer_conv_irq_req, irq}, 32'h1FE);
      apb(1, IRQ_MASK_ADDR, 32'hFFF);
      check(irq, 1);
      apb(1, IRQ_STAT_ADDR, 32'hC3F);
      check({serial_irq_req, timer_conv_irq_req, irq}, 0);
      @(posedge clk);
      key <= 4'hF;
      repeat (6) @(posedge clk);
      apb(0, KEY_FLAG_ADDR, 0);
      check(rd, 32'h3C);
      check(key_irq_req, 4'hF);
      seed = lfsr(seed);
      apb(1, KEY_FLAG_ADDR, seed);
      apb(0, KEY_FLAG_ADDR, 0);
      check(rd, seed & 32'h3C);
      final_report;
   end
endmodule : irq_enable_and_key_flag_regs_bench

// file: dv/irq_regs_monitor.sv
// Purpose: port assertions for the serial and timer/converter enable registers
// Assumes: one-cycle apb access
// Notes:   enables are seen only through the request outputs
module irq_regs_monitor
   import irq_regs_pkg::*;
(
   // clock and reset
   input wire logic                            clk,
   input wire logic                            rst_n,
   // apb
   input wire logic                            psel,
   input wire logic                            penable,
   input wire logic                            pwrite,
   input wire logic [irq_regs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                     pwdata,
   input wire logic [3:0]                      pstrb,
   input wire logic [31:0]                     prdata,
   // events and requests
   input wire logic                            ser1_tx_empty_ev,
   input wire logic [5:0]                      serial_irq_req,
   input wire logic [1:0]                      timer_conv_irq_req,
   input wire logic                            irq
);
   // ****
   // decode
   // ****
   wire wr  = psel & penable & pwrite & pstrb[0];
   wire wse = wr & (paddr == SERIAL_EN_ADDR);
   wire wtc = wr & (paddr == TIMCONV_EN_ADDR);
   wire rtc = psel & penable & !pwrite & (paddr == TIMCONV_EN_ADDR);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_ser1_tx_off: assert property (wse && !pwdata[5] |=>
      !serial_irq_req[5]) else $error("ser1 tx");
   chk_ser1_rx_off: assert property (wse && pwdata[4:3] == 2'h0 |=>
      serial_irq_req[4:3] == 2'h0) else $error("ser1 rx");
   chk_ser0_off: assert property (wse && pwdata[2:0] == 3'h0 |=>
      serial_irq_req[2:0] == 3'h0) else $error("ser0");
   chk_timer_off: assert property (wtc && pwdata[1:0] == 2'h0 |=>
      timer_conv_irq_req == 2'h0) else $error("timer");
   chk_reset_zero: assert property ($rose(rst_n) |->
      serial_irq_req == 6'h0 && timer_conv_irq_req == 2'h0 && !irq)
      else $error("reset");
   chk_rsvd_ones: assert property (rtc |->
      prdata[31:2] == 30'h3F) else $error("reserved bits");
   chk_req_cause: assert property ($rose(serial_irq_req[5]) |->
      $past(ser1_tx_empty_ev) || $past(wse)) else $error("no cause");
   chk_timer_drop: assert property ($fell(timer_conv_irq_req[1]) &&
      $past(rst_n) |-> $past(wr && (paddr == TIMCONV_EN_ADDR ||
      paddr == IRQ_STAT_ADDR))) else $error("timer lost");
   cov_irq: cover property ($rose(irq));
   cov_ser: cover property (serial_irq_req == 6'h3F);
   cov_rsvd: cover property (rtc);
endmodule : irq_regs_monitor

bind irq_enable_and_key_flag_regs irq_regs_monitor irq_regs_monitor_i (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .ser1_tx_empty_ev(ser1_tx_empty_ev),
   .serial_irq_req(serial_irq_req),
   .timer_conv_irq_req(timer_conv_irq_req), .irq(irq));

// file: logic/irq_edge.sv
// Purpose: rising edge detect of synchronised levels
// Assumes: inputs already on clk
// Notes:   a level held high raises only one event

module irq_edge #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels in, pulses out
   input  wire logic [W-1:0] lvl,
   output logic      [W-1:0] rise
);
   logic [W-1:0] prev_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_r <= '0;
      end else begin
         prev_r <= lvl;
      end
   end

   assign rise = lvl & ~prev_r;
endmodule : irq_edge

// file: logic/irq_enable_and_key_flag_regs.sv
// Purpose: serial, timer and converter interrupt enables, key factor flags
// Assumes: APB slave, zero wait states, event pulses on clk
// Notes:   key pins are asynchronous and pass a synchroniser
//
// What this block does
// - serial channel 1 transmit-empty enable at bit 5, resets to 0
// - serial channel 1 receive-full enable bit 4, error bit 3, reset 0
// - serial channel 0 transmit 2, receive 1, error 0 enables, reset 0
// - timer/converter enable bit 1 gates the converter status (bit 11), bit 0 the clock timer status (bit 10), reset 0
// - port-5 group flag bit 5, port-6 group flag bit 4, read/write

module irq_enable_and_key_flag_regs
   import irq_regs_pkg::*;
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [irq_regs_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // peripheral event pulses, on clk
   input  wire logic                     ser1_tx_empty_ev,
   input  wire logic                     ser1_rx_full_ev,
   input  wire logic                     ser1_rx_error_ev,
   input  wire logic                     ser0_tx_empty_ev,
   input  wire logic                     ser0_rx_full_ev,
   input  wire logic                     ser0_rx_error_ev,
   input  wire logic                     clock_timer_ev,
   input  wire logic                     converter_done_ev,
   // key input pins, asynchronous
   input  wire logic                     port5_group_in,
   input  wire logic                     port6_group_in,
   input  wire logic                     key_line4_in,
   input  wire logic                     key_line5_in,
   // requests toward the processor
   output logic      [5:0]               serial_irq_req,
   output logic      [1:0]               timer_conv_irq_req,
   output logic      [3:0]               key_irq_req,
   output logic                          irq
);
   import irq_regs_pkg::*;

   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0]       ser_en_r;
   logic [7:0]       ser_en_nxt;
   logic [1:0]       tc_en_r;
   logic [1:0]       tc_en_nxt;
   logic [N_KEY-1:0] key_en_r;
   logic [N_KEY-1:0] key_en_nxt;
   logic [N_KEY-1:0] key_flag_r;
   logic [N_KEY-1:0] key_flag_nxt;
   logic [N_SRC-1:0] stat_r;
   logic [N_SRC-1:0] stat_nxt;
   logic [N_SRC-1:0] mask_r;
   logic [N_SRC-1:0] mask_nxt;
   logic [31:0]      prdata_r;
   logic [31:0]      prdata_nxt;

   // ************************************************************
   // apb decode
   // ************************************************************
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] b);
      hit = (a == b);
   endfunction : hit

   wire acc      = psel & penable;
   wire wr       = acc & pwrite & pstrb[0];
   wire rd_setup = psel & ~penable & ~pwrite;
   wire sel_ser  = hit(paddr, SERIAL_EN_ADDR);
   wire sel_tc   = hit(paddr, TIMCONV_EN_ADDR);
   wire sel_key  = hit(paddr, KEY_FLAG_ADDR);
   wire sel_stat = hit(paddr, IRQ_STAT_ADDR);
   wire sel_mask = hit(paddr, IRQ_MASK_ADDR);
   wire mapped   = sel_ser | sel_tc | sel_key | sel_stat | sel_mask;

   // zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata  = prdata_r;

   // ************************************************************
   // key inputs
   // ************************************************************
   logic [N_KEY-1:0] key_sync;
   logic [N_KEY-1:0] key_rise;

   irq_sync2 #(.W(N_KEY)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({port5_group_in, port6_group_in, key_line4_in,
               key_line5_in}),
      .q     (key_sync)
   );

   irq_edge #(.W(N_KEY)) u_edge (
      .clk   (clk),
      .rst_n (rst_n),
      .lvl   (key_sync),
      .rise  (key_rise)
   );

   // ************************************************************
   // next state
   // ************************************************************
   // flag bits 5..2 map to key vector 3..0
   wire [N_KEY-1:0] key_wdata = pwdata[P5_GRP_POS:KEY5_POS];
   // key bits 9..6 are left empty here and come from key_rise below
   wire [N_SRC-1:0] ser_ev = {converter_done_ev, clock_timer_ev, 4'h0,
                              ser1_tx_empty_ev, ser1_rx_full_ev,
                              ser1_rx_error_ev, ser0_tx_empty_ev,
                              ser0_rx_full_ev, ser0_rx_error_ev};
   wire [N_SRC-1:0] all_ev = ser_ev | {2'b00, key_rise, 6'h00};
   wire [N_SRC-1:0] req_vec;

   always_comb begin
      ser_en_nxt   = ser_en_r;
      tc_en_nxt    = tc_en_r;
      key_en_nxt   = key_en_r;
      key_flag_nxt = key_flag_r;
      stat_nxt     = stat_r;
      mask_nxt     = mask_r;
      if (wr && sel_ser) begin
         ser_en_nxt = {2'b00, pwdata[SER1_TX_POS:SER0_ERR_POS]};
      end
      if (wr && sel_tc) begin
         // reserved ones are expected from software, not stored
         tc_en_nxt = pwdata[CTM_POS:ADC_POS];
      end
      if (wr && sel_key) begin
         key_flag_nxt = key_wdata;
      end
      if (wr && sel_mask) begin
         mask_nxt = pwdata[N_SRC-1:0];
         key_en_nxt = pwdata[9:6];
      end
      if (wr && sel_stat) begin
         stat_nxt = stat_nxt & ~pwdata[N_SRC-1:0];
      end
      // set wins over a same-cycle write or clear
      key_flag_nxt = key_flag_nxt | key_rise;
      stat_nxt     = stat_nxt | all_ev;
   end

   always_comb begin
      prdata_nxt = 32'h0000_0000;
      if (rd_setup) begin
         if (sel_ser) begin
            prdata_nxt = {24'h000000, ser_en_r};
         end else if (sel_tc) begin
            prdata_nxt = {24'h000000, TIMCONV_RSVD | {6'h00, tc_en_r}};
         end else if (sel_key) begin
            prdata_nxt = {24'h000000, 2'b00, key_flag_r, 2'b00};
         end else if (sel_stat) begin
            prdata_nxt = {20'h00000, stat_r};
         end else if (sel_mask) begin
            prdata_nxt = {20'h00000, mask_r};
         end else begin
            prdata_nxt = 32'h0000_0000;
         end
      end else begin
         prdata_nxt = prdata_r;
      end
   end

   // ************************************************************
   // state
   // ************************************************************
   // key flags are undefined in hardware; zero here for determinism
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ser_en_r   <= SERIAL_EN_RST;
         tc_en_r    <= TIMCONV_EN_RST[1:0];
         key_en_r   <= '0;
         key_flag_r <= KEY_FLAG_RST[N_KEY-1:0];
         stat_r     <= STAT_RST;
         mask_r     <= MASK_RST;
         prdata_r   <= 32'h0000_0000;
      end else begin
         ser_en_r   <= ser_en_nxt;
         tc_en_r    <= tc_en_nxt;
         key_en_r   <= key_en_nxt;
         key_flag_r <= key_flag_nxt;
         stat_r     <= stat_nxt;
         mask_r     <= mask_nxt;
         prdata_r   <= prdata_nxt;
      end
   end

   // ************************************************************
   // requests
   // ************************************************************
   assign serial_irq_req     = ser_en_r[5:0] & stat_r[5:0];
   assign timer_conv_irq_req = tc_en_r & stat_r[11:10];
   assign key_irq_req        = key_en_r & key_flag_r;
   assign req_vec            = stat_r & mask_r;
   assign irq                = |req_vec;

endmodule : irq_enable_and_key_flag_regs

// file: logic/irq_regs_pkg.sv
// Purpose: constants for the interrupt enable and key flag register slice
// Assumes: 32-bit APB, one register per aligned word
// Notes:   three printed offsets are not multiples of four, so all are indices

package irq_regs_pkg;

   // ************************************************************
   // register indices and byte addresses
   // ************************************************************
   localparam logic [19:0] SERIAL_EN_IDX  = 20'h40276;
   localparam logic [19:0] TIMCONV_EN_IDX = 20'h40277;
   localparam logic [19:0] KEY_FLAG_IDX   = 20'h40280;
   localparam logic [19:0] IRQ_STAT_IDX   = 20'h40288;
   localparam logic [19:0] IRQ_MASK_IDX   = 20'h40289;
   localparam int          ADDR_W         = 22;

   localparam logic [ADDR_W-1:0] SERIAL_EN_ADDR  = {SERIAL_EN_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] TIMCONV_EN_ADDR = {TIMCONV_EN_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] KEY_FLAG_ADDR   = {KEY_FLAG_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR   = {IRQ_STAT_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = {IRQ_MASK_IDX, 2'b00};

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int SER1_TX_POS  = 5;
   localparam int SER1_RX_POS  = 4;
   localparam int SER1_ERR_POS = 3;
   localparam int SER0_TX_POS  = 2;
   localparam int SER0_RX_POS  = 1;
   localparam int SER0_ERR_POS = 0;
   localparam int CTM_POS      = 1;
   localparam int ADC_POS      = 0;
   localparam int P5_GRP_POS   = 5;
   localparam int P6_GRP_POS   = 4;
   localparam int KEY4_POS     = 3;
   localparam int KEY5_POS     = 2;

   localparam int N_SRC  = 12;
   localparam int N_KEY  = 4;
   localparam logic [7:0] SERIAL_EN_RST  = 8'h00;
   localparam logic [7:0] TIMCONV_EN_RST = 8'h00;
   localparam logic [7:0] TIMCONV_RSVD   = 8'hFC;
   localparam logic [7:0] KEY_FLAG_RST   = 8'h00;
   localparam logic [N_SRC-1:0] STAT_RST = 12'h000;
   localparam logic [N_SRC-1:0] MASK_RST = 12'h000;

endpackage : irq_regs_pkg

// file: logic/irq_sync2.sv
// Purpose: two-flop synchroniser for asynchronous event inputs
// Assumes: single clock domain
// Notes:   first stage feeds only the second

module irq_sync2 #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : irq_sync2
